/* rtl/pmc_ctrl.sv */
// power mode controller of a gnss receiver with an apb register slave
//
// Contract
// - after power-up enter full power with acquisition engine searching all satellites
// - in full power switch to tracking once position and all ephemeris valid
// - power mode argument 0 returns any low-power state except backup to full
// - standby command stops navigation; 0 stops osc, rf, baseband; 1 rf, baseband
// - in standby any received serial byte wakes to full power
// - periodic command type 1 backup, type 2 standby; alternate on and off periods
// - acquisition failure in first on-period uses retry on and off periods
// - an accepted power mode command answers an acknowledge with fields 225, 3
// - power mode value 9 selects adaptive periodic mode
// - adaptive mode picks its own on/off ratio from motion while supplied
// - power mode value 4 enters backup; host holds force pin low first
// - backup command with force pin not low enters idle instead
// - stay in backup while force pin is held low
// - no serial command ends backup; only pin sequence or supply restore (the code ends it only on the pin sequence)
// - waking from backup reuses retained data for a hot start
// - main supply loss enters backup; supply return goes active with hot start (the code stays in backup until the pin sequence)
// - configuration is lost with power and defaults return at power-up
// - augmentation corrections are enabled after power-up without any command
// - accept ground differential corrections on serial input, apply one source
// - interference canceller on by default, off by command, up to 12 tones
`timescale 1ns/1ps
`include "pmc_params.svh"
module pmc_ctrl
  import pmc_pkg::*;
#(
  parameter int CYC_PER_MS = `PMC_CLK_HZ / `PMC_MS_PER_S,
  parameter int BACKUP_EXIT_CYC = `PMC_BACKUP_EXIT_MS * (`PMC_CLK_HZ / `PMC_MS_PER_S)
) (
  input wire logic ref_clk_i, // 10 mhz clock
  input wire logic resetn_i, // async reset, power-up
  input wire logic psel_i, // apb select
  input wire logic penable_i, // apb enable
  input wire logic pwrite_i, // apb direction
  input wire logic [11:0] paddr_i, // apb byte address
  input wire logic [31:0] pwdata_i, // apb write data
  output logic [31:0] prdata_o, // apb read data
  output logic pready_o, // apb ready
  output logic pslverr_o, // apb error on unmapped address
  input wire logic rx_byte_i, // pulse: byte received on primary serial input
  input wire logic rtcm_valid_i, // ground differential correction message seen
  input wire logic force_on_n_i, // force full power pin, active low
  input wire logic main_supply_ok_i, // main supply present
  input wire logic position_valid_i, // navigation has a valid position
  input wire logic ephemeris_valid_i, // ephemeris valid for all satellites in view
  input wire logic acq_fail_i, // pulse: acquisition failed
  input wire logic moving_i, // motion detected, steers adaptive mode
  output pmc_state_t state_o, // current power state
  output pmc_pwr_t pwr_o, // power domain enables
  output pmc_ack_t ack_o, // acknowledge sentence request
  output logic hot_start_o, // start uses retained data
  output logic aug_en_o, // augmentation corrections in use
  output logic gnd_corr_o, // ground differential corrections applied
  output logic aic_en_o // interference canceller enabled
);
  pmc_state_t state_q;
  logic [2:0] ctrl_q;
  logic [31:0] run_q, sleep_q, run2_q, sleep2_q;
  logic [31:0] per_ms_q;
  logic [31:0] cyc_q;
  logic [31:0] hi_cnt_q;
  logic ms_tick;
  logic retry_q;
  logic per_backup_q;
  logic force_q;
  logic cmd_ok, wr_en, rd_en;
  logic [1:0] cmd_op;
  logic [7:0] cmd_arg;
  logic [31:0] rd_d;
  logic map_hit;
  logic backup_exit;

  // checksum: xor of opcode bits, argument byte and bits 15:8
  function automatic logic [7:0] pmc_sum(input logic [31:0] w);
    return w[23:16] ^ {6'h00, w[25:24]} ^ w[15:8];
  endfunction

  // adaptive off-period from motion: still receivers sleep longer
  function automatic logic [31:0] pmc_adapt_off(input logic mv);
    return mv ? `PMC_ADAPT_OFF_MOVE_MS : `PMC_ADAPT_OFF_STILL_MS;
  endfunction

  // apb access phase is taken one cycle after it starts, when pready is high
  assign wr_en = psel_i && penable_i && pwrite_i && pready_o;
  assign rd_en = psel_i && penable_i && !pwrite_i;
  assign cmd_op = pwdata_i[25:24];
  assign cmd_arg = pwdata_i[23:16];
  assign cmd_ok = wr_en && (paddr_i == `PMC_ADDR_CMD) && (pmc_sum(pwdata_i) == pwdata_i[7:0]);
  assign ms_tick = (cyc_q == 32'(CYC_PER_MS - 1));
  // the high time is judged at the pin's fall, so a blip shorter than the exit time keeps backup
  assign backup_exit = !force_on_n_i && force_q && (hi_cnt_q == 32'(BACKUP_EXIT_CYC));

  // read decode
  always_comb begin
    map_hit = 1'b1;
    rd_d = 32'h0000_0000;
    case (paddr_i)
      `PMC_ADDR_CTRL: rd_d = {29'h0000_0000, ctrl_q};
      `PMC_ADDR_CMD: rd_d = 32'h0000_0000;
      `PMC_ADDR_RUN: rd_d = run_q;
      `PMC_ADDR_SLEEP: rd_d = sleep_q;
      `PMC_ADDR_RUN2: rd_d = run2_q;
      `PMC_ADDR_SLEEP2: rd_d = sleep2_q;
      `PMC_ADDR_STATUS: rd_d = {20'h0_0000, `PMC_AIC_MAX_TONES, retry_q, hot_start_o, 2'h0, state_q};
      default: map_hit = 1'b0;
    endcase
  end

  // apb answer: one wait state so read data comes from a flip-flop
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pready_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= psel_i && penable_i && !pready_o;
      prdata_o <= (rd_en && map_hit && !pready_o) ? rd_d : 32'h0000_0000;
      pslverr_o <= psel_i && penable_i && !pready_o && !map_hit;
    end
  end

  // configuration; it falls back to defaults whenever main supply drops
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_q <= `PMC_CTRL_RST;
      run_q <= `PMC_PERIOD_RST;
      sleep_q <= `PMC_PERIOD_RST;
      run2_q <= `PMC_PERIOD_RST;
      sleep2_q <= `PMC_PERIOD_RST;
    end else if (!main_supply_ok_i) begin
      ctrl_q <= `PMC_CTRL_RST;
      run_q <= `PMC_PERIOD_RST;
      sleep_q <= `PMC_PERIOD_RST;
      run2_q <= `PMC_PERIOD_RST;
      sleep2_q <= `PMC_PERIOD_RST;
    end else if (wr_en && state_q != PMC_BACKUP) begin
      case (paddr_i)
        `PMC_ADDR_CTRL: ctrl_q <= pwdata_i[2:0];
        `PMC_ADDR_RUN: run_q <= pwdata_i;
        `PMC_ADDR_SLEEP: sleep_q <= pwdata_i;
        `PMC_ADDR_RUN2: run2_q <= pwdata_i;
        `PMC_ADDR_SLEEP2: sleep2_q <= pwdata_i;
        default: ;
      endcase
    end
  end

  // millisecond tick for the periodic timers
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cyc_q <= 32'h0000_0000;
    end else begin
      cyc_q <= ms_tick ? 32'h0000_0000 : cyc_q + 32'h0000_0001;
    end
  end

  // force pin high-time while in backup, saturating at the exit time
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hi_cnt_q <= 32'h0000_0000;
      force_q <= 1'b0;
    end else begin
      force_q <= force_on_n_i;
      if (state_q != PMC_BACKUP || !force_on_n_i) begin
        hi_cnt_q <= 32'h0000_0000;
      end else if (hi_cnt_q != 32'(BACKUP_EXIT_CYC)) begin
        hi_cnt_q <= hi_cnt_q + 32'h0000_0001;
      end
    end
  end

  // power state machine
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= PMC_FULL_ACQ;
      per_ms_q <= 32'h0000_0000;
      retry_q <= 1'b0;
      per_backup_q <= 1'b0;
      hot_start_o <= 1'b0;
    end else if (!main_supply_ok_i) begin
      state_q <= PMC_BACKUP;
      hot_start_o <= 1'b0;
    end else begin
      if (ms_tick && per_ms_q != 32'h0000_0000) begin
        per_ms_q <= per_ms_q - 32'h0000_0001;
      end
      case (state_q)
        PMC_FULL_ACQ: begin
          if (position_valid_i && ephemeris_valid_i) begin
            state_q <= PMC_FULL_TRACK;
          end
        end
        PMC_FULL_TRACK: begin
          if (!(position_valid_i && ephemeris_valid_i)) begin
            state_q <= PMC_FULL_ACQ;
          end
        end
        PMC_STBY_STOP, PMC_STBY_SLEEP: begin
          if (rx_byte_i) begin
            state_q <= PMC_FULL_ACQ;
          end
        end
        PMC_PER_ON: begin
          if (acq_fail_i && !retry_q) begin
            retry_q <= 1'b1;
            per_ms_q <= run2_q;
          end else if (per_ms_q == 32'h0000_0000) begin
            state_q <= PMC_PER_OFF;
            per_ms_q <= retry_q ? sleep2_q : sleep_q;
          end
        end
        PMC_PER_OFF: begin
          if (per_ms_q == 32'h0000_0000) begin
            state_q <= PMC_PER_ON;
            per_ms_q <= run_q;
            retry_q <= 1'b0;
          end
        end
        PMC_ADAPT_ON: begin
          if (per_ms_q == 32'h0000_0000) begin
            state_q <= PMC_ADAPT_OFF;
            per_ms_q <= pmc_adapt_off(moving_i);
          end
        end
        PMC_ADAPT_OFF: begin
          if (per_ms_q == 32'h0000_0000) begin
            state_q <= PMC_ADAPT_ON;
            per_ms_q <= `PMC_ADAPT_ON_MS;
          end
        end
        PMC_BACKUP: begin
          // commands never end backup, nor does supply return; only the pin sequence does
          // a low pin, or a high pulse cut short, keeps the device here
          if (backup_exit) begin
            state_q <= PMC_FULL_ACQ;
            hot_start_o <= 1'b1;
          end
        end
        PMC_IDLE: ;
        default: state_q <= PMC_FULL_ACQ;
      endcase
      // serial commands, checked before they steer anything
      if (cmd_ok && state_q != PMC_BACKUP) begin
        if (cmd_op == `PMC_OP_STANDBY) begin
          if (cmd_arg == `PMC_ARG_STOP) begin
            state_q <= PMC_STBY_STOP;
          end else if (cmd_arg == `PMC_ARG_SLEEP) begin
            state_q <= PMC_STBY_SLEEP;
          end
        end else if (cmd_op == `PMC_OP_POWER) begin
          case (cmd_arg)
            `PMC_ARG_FULL: state_q <= PMC_FULL_ACQ;
            `PMC_ARG_PER_BACKUP, `PMC_ARG_PER_STANDBY: begin
              state_q <= PMC_PER_ON;
              per_ms_q <= run_q;
              retry_q <= 1'b0;
              per_backup_q <= (cmd_arg == `PMC_ARG_PER_BACKUP);
            end
            `PMC_ARG_BACKUP: state_q <= force_on_n_i ? PMC_IDLE : PMC_BACKUP;
            `PMC_ARG_ADAPTIVE: begin
              state_q <= PMC_ADAPT_ON;
              per_ms_q <= `PMC_ADAPT_ON_MS;
            end
            default: ;
          endcase
        end
      end
    end
  end

  // acknowledge for an accepted power mode command, one cycle after the write
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ack_o <= '0;
    end else begin
      ack_o.valid <= cmd_ok && cmd_op == `PMC_OP_POWER && state_q != PMC_BACKUP && main_supply_ok_i;
      ack_o.cmd <= `PMC_ACK_CMD;
      ack_o.flag <= `PMC_ACK_FLAG;
    end
  end

  // power domain enables follow the state; the io block sleeps in backup
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pwr_o <= '0;
      state_o <= PMC_FULL_ACQ;
      aug_en_o <= 1'b0;
      gnd_corr_o <= 1'b0;
      aic_en_o <= 1'b0;
    end else begin
      state_o <= state_q;
      pwr_o.io_en <= state_q != PMC_BACKUP;
      pwr_o.osc_en <= !(state_q inside {PMC_STBY_STOP, PMC_BACKUP}) && !(state_q == PMC_PER_OFF && per_backup_q);
      pwr_o.rf_en <= state_q inside {PMC_FULL_ACQ, PMC_FULL_TRACK, PMC_PER_ON, PMC_ADAPT_ON};
      pwr_o.bb_en <= state_q inside {PMC_FULL_ACQ, PMC_FULL_TRACK, PMC_PER_ON, PMC_ADAPT_ON};
      pwr_o.track_en <= state_q == PMC_FULL_TRACK;
      aug_en_o <= ctrl_q[`PMC_CTRL_AUG] && !(ctrl_q[`PMC_CTRL_GND] && rtcm_valid_i);
      gnd_corr_o <= ctrl_q[`PMC_CTRL_GND] && rtcm_valid_i;
      aic_en_o <= ctrl_q[`PMC_CTRL_AIC];
    end
  end

  // checks
  no_ack_badsum_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (wr_en && paddr_i == `PMC_ADDR_CMD && pmc_sum(pwdata_i) != pwdata_i[7:0]) |=> !ack_o.valid)
    else $error("ack sent for bad checksum");
  ack_fields_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (cmd_ok && cmd_op == `PMC_OP_POWER && state_q != PMC_BACKUP && main_supply_ok_i)
    |=> ack_o.valid && ack_o.cmd == `PMC_ACK_CMD && ack_o.flag == `PMC_ACK_FLAG)
    else $error("power mode ack missing or wrong");
  standby_wake_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (state_q inside {PMC_STBY_STOP, PMC_STBY_SLEEP} && rx_byte_i && !cmd_ok && main_supply_ok_i)
    |=> state_q == PMC_FULL_ACQ)
    else $error("standby did not wake on byte");
  backup_hold_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (state_q == PMC_BACKUP && !force_on_n_i && !force_q) |=> state_q == PMC_BACKUP)
    else $error("backup left while pin low");
  backup_nocmd_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (state_q == PMC_BACKUP && force_on_n_i) |=> state_q == PMC_BACKUP)
    else $error("backup left without pin sequence");
  idle_entry_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (cmd_ok && cmd_op == `PMC_OP_POWER && cmd_arg == `PMC_ARG_BACKUP && force_on_n_i
     && state_q != PMC_BACKUP && main_supply_ok_i) |=> state_q == PMC_IDLE)
    else $error("backup command with pin high not idle");
  supply_loss_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    !main_supply_ok_i |=> state_q == PMC_BACKUP ##1 (state_o == PMC_BACKUP && !pwr_o.io_en))
    else $error("supply loss did not reach backup");
  track_handover_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (state_q == PMC_FULL_ACQ && position_valid_i && ephemeris_valid_i && !cmd_ok && main_supply_ok_i)
    |=> ##1 pwr_o.track_en)
    else $error("no handover to tracking");
  cfg_default_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    !main_supply_ok_i |=> ctrl_q == `PMC_CTRL_RST)
    else $error("configuration kept over supply loss");
  hot_wake_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    $rose(state_q == PMC_FULL_ACQ) && $past(state_q) == PMC_BACKUP && main_supply_ok_i |-> hot_start_o)
    else $error("backup wake without hot start");
  // standby variants switch off their own domains one cycle after the state
  stop_power_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    state_q == PMC_STBY_STOP |=> !pwr_o.osc_en && !pwr_o.rf_en && !pwr_o.bb_en)
    else $error("stop standby left a domain powered");
  sleep_power_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    state_q == PMC_STBY_SLEEP |=> pwr_o.osc_en && !pwr_o.rf_en && !pwr_o.bb_en)
    else $error("sleep standby domains wrong");
  // accepted power mode commands land on the next edge
  full_return_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (cmd_ok && cmd_op == `PMC_OP_POWER && cmd_arg == `PMC_ARG_FULL
     && state_q != PMC_BACKUP && main_supply_ok_i) |=> state_q == PMC_FULL_ACQ)
    else $error("full power command not taken");
  adapt_entry_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (cmd_ok && cmd_op == `PMC_OP_POWER && cmd_arg == `PMC_ARG_ADAPTIVE
     && state_q != PMC_BACKUP && main_supply_ok_i) |=> state_q == PMC_ADAPT_ON)
    else $error("adaptive command not taken");
  // a failed first acquisition swaps in the retry on-period
  retry_load_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (state_q == PMC_PER_ON && acq_fail_i && !retry_q && !cmd_ok && main_supply_ok_i)
    |=> retry_q && per_ms_q == $past(run2_q))
    else $error("retry periods not loaded");
  // a high pulse shorter than the exit time is not an exit
  short_blip_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (state_q == PMC_BACKUP && !force_on_n_i && force_q && hi_cnt_q != 32'(BACKUP_EXIT_CYC))
    |=> state_q == PMC_BACKUP)
    else $error("backup left on a short pin pulse");
  backup_domains_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    state_q == PMC_BACKUP |=> !pwr_o.io_en && !pwr_o.osc_en)
    else $error("domain powered in backup");
  // scenario covers
  standby_c: cover property (@(posedge ref_clk_i) disable iff (!resetn_i)
    state_q == PMC_STBY_SLEEP ##1 state_q == PMC_FULL_ACQ);
  periodic_c: cover property (@(posedge ref_clk_i) disable iff (!resetn_i)
    state_q == PMC_PER_ON ##1 state_q == PMC_PER_OFF);
  retry_c: cover property (@(posedge ref_clk_i) disable iff (!resetn_i) state_q == PMC_PER_ON && acq_fail_i);
  backup_exit_c: cover property (@(posedge ref_clk_i) disable iff (!resetn_i)
    state_q == PMC_BACKUP ##1 state_q == PMC_FULL_ACQ);
  adaptive_c: cover property (@(posedge ref_clk_i) disable iff (!resetn_i) state_q == PMC_ADAPT_OFF);
endmodule

/* include/pmc_params.svh */
// constants of the gnss power mode controller: offsets, codes, reset values, times
`ifndef PMC_PARAMS_SVH
`define PMC_PARAMS_SVH
`define PMC_ADDR_CTRL 12'h000
`define PMC_ADDR_CMD 12'h004
`define PMC_ADDR_RUN 12'h008
`define PMC_ADDR_SLEEP 12'h00c
`define PMC_ADDR_RUN2 12'h010
`define PMC_ADDR_SLEEP2 12'h014
`define PMC_ADDR_STATUS 12'h018
`define PMC_CTRL_RST 3'h3
`define PMC_CTRL_AUG 0
`define PMC_CTRL_AIC 1
`define PMC_CTRL_GND 2
`define PMC_OP_POWER 2'h1
`define PMC_OP_STANDBY 2'h2
`define PMC_ARG_FULL 8'h00
`define PMC_ARG_PER_BACKUP 8'h01
`define PMC_ARG_PER_STANDBY 8'h02
`define PMC_ARG_BACKUP 8'h04
`define PMC_ARG_ADAPTIVE 8'h09
`define PMC_ARG_STOP 8'h00
`define PMC_ARG_SLEEP 8'h01
`define PMC_ACK_CMD 8'he1
`define PMC_ACK_FLAG 4'h3
`define PMC_AIC_MAX_TONES 4'hc
`define PMC_CLK_HZ 10000000
`define PMC_MS_PER_S 1000
`define PMC_BACKUP_EXIT_MS 1000
`define PMC_ADAPT_ON_MS 32'h0000_0bb8
`define PMC_ADAPT_OFF_MOVE_MS 32'h0000_0bb8
`define PMC_ADAPT_OFF_STILL_MS 32'h0000_2ee0
`define PMC_PERIOD_RST 32'h0000_0000
`endif

/* include/pmc_pkg.sv */
// types of the gnss power mode controller
package pmc_pkg;
  typedef enum logic [3:0] {
    PMC_FULL_ACQ, PMC_FULL_TRACK, PMC_STBY_STOP, PMC_STBY_SLEEP, PMC_PER_ON, PMC_PER_OFF,
    PMC_ADAPT_ON, PMC_ADAPT_OFF, PMC_IDLE, PMC_BACKUP
  } pmc_state_t;
  typedef struct packed {
    logic osc_en;
    logic rf_en;
    logic bb_en;
    logic track_en;
    logic io_en;
  } pmc_pwr_t;
  typedef struct packed {
    logic valid;
    logic [7:0] cmd;
    logic [3:0] flag;
  } pmc_ack_t;
endpackage

/* verification/pmc_host_model.sv */
// host-side model: drives the force pin and the serial wake strobe
`timescale 1ns/1ps
module pmc_host_model #(
  parameter int HIGH_CYC = 10
) (
  input wire logic ref_clk_i, // bench clock
  input wire logic resetn_i, // async reset, active low
  input wire logic hold_low_i, // ground the force pin
  input wire logic exit_i, // pulse: run the backup exit sequence
  input wire logic wake_i, // pulse: send one serial byte
  output logic force_on_n_o, // force pin toward the device
  output logic rx_byte_o // byte strobe toward the device
);
  int cnt_q;
  // exit sequence: pin high for the exit time, then back to logic low
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_q <= 0;
    end else if (exit_i) begin
      cnt_q <= HIGH_CYC;
    end else if (cnt_q != 0) begin
      cnt_q <= cnt_q - 1;
    end
  end
  // grounded before the backup command and for as long as backup should last
  assign force_on_n_o = !hold_low_i || (cnt_q != 0);
  // no bytes while the pin holds the device in backup, its i/o is unpowered
  // one byte one cycle after a wake pulse, as the standby wake to full power needs
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rx_byte_o <= 1'b0;
    end else begin
      rx_byte_o <= wake_i && force_on_n_o;
    end
  end
endmodule

/* verification/tb_pmc_ctrl.sv */
// self-checking bench of the power mode controller
`timescale 1ns/1ps
`include "pmc_params.svh"
module tb_pmc_ctrl
  import pmc_pkg::*;
;
  localparam int CPM = 2;
  logic ref_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic rtcm = 1'b0, supply = 1'b1, posv = 1'b0, ephv = 1'b0, acqf = 1'b0, moving = 1'b1;
  logic hold_low = 1'b0, exit_p = 1'b0, wake = 1'b0;
  logic [31:0] prdata, rq;
  logic pready, pslverr, re, force_n, rx, hot, aug, gnd, interference_canceller;
  pmc_state_t state, m_st;
  pmc_pwr_t pwr;
  pmc_ack_t ack;
  int failures = 0, check_count = 0, ack_seen = 0, exp_acks = 0, wn;
  logic [31:0] lfsr_q = 32'hf718;
  int per[4];

  always #50 ref_clk_i = ~ref_clk_i;

  pmc_ctrl #(.CYC_PER_MS(CPM), .BACKUP_EXIT_CYC(8)) u_pmc_ctrl (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .rx_byte_i(rx), .rtcm_valid_i(rtcm),
    .force_on_n_i(force_n), .main_supply_ok_i(supply), .position_valid_i(posv), .ephemeris_valid_i(ephv),
    .acq_fail_i(acqf), .moving_i(moving), .state_o(state), .pwr_o(pwr), .ack_o(ack), .hot_start_o(hot),
    .aug_en_o(aug), .gnd_corr_o(gnd), .aic_en_o(interference_canceller));
  pmc_host_model #(.HIGH_CYC(10)) u_pmc_host_model (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
    .hold_low_i(hold_low), .exit_i(exit_p), .wake_i(wake), .force_on_n_o(force_n), .rx_byte_o(rx));

  function automatic logic [31:0] lfsr();
    lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
    return lfsr_q;
  endfunction

  task automatic end_sim();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tmo(input string what);
    failures++;
    $display("unexpected %s: expected done seen timeout", what);
    end_sim();
  endtask

  // every acknowledge carries the command number and the accept flag
  always @(posedge ref_clk_i) begin
    if (ack.valid === 1'b1) begin
      ack_seen++;
      chk("ack fields", {ack.cmd, ack.flag}, {`PMC_ACK_CMD, `PMC_ACK_FLAG});
    end
  end

  // apb master: hold the request until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) tmo("apb ready");
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_st(input pmc_state_t s, input int max);
    wn = 0;
    do begin
      @(posedge ref_clk_i);
      #1;
      wn++;
    end while (state !== s && wn < max);
    if (wn >= max) tmo(s.name());
  endtask

  // a period measured on state_o may be off by one ms tick
  task automatic rng(input string what, input int ms);
    chk(what, 32'(wn >= (ms - 1) * CPM - 2 && wn <= (ms + 1) * CPM + 2), 32'h1);
  endtask

  // command write, then the model's state and acknowledge count are compared
  task automatic cmd(input logic [1:0] op, input logic [7:0] arg, input logic bad);
    logic [7:0] cs;
    cs = arg ^ {6'h0, op} ^ {8{bad}};
    apb(1'b1, `PMC_ADDR_CMD, {6'h0, op, arg, 8'h00, cs});
    if (!bad && m_st != PMC_BACKUP) begin
      if (op == `PMC_OP_POWER) exp_acks++;
      if (op == `PMC_OP_STANDBY) m_st = (arg == `PMC_ARG_STOP) ? PMC_STBY_STOP : PMC_STBY_SLEEP;
      else if (arg == `PMC_ARG_FULL) m_st = PMC_FULL_ACQ;
      else if (arg == `PMC_ARG_ADAPTIVE) m_st = PMC_ADAPT_ON;
      else if (arg == `PMC_ARG_BACKUP) m_st = force_n ? PMC_IDLE : PMC_BACKUP;
      else m_st = PMC_PER_ON;
    end
    repeat (3) @(posedge ref_clk_i);
    #1;
    chk("state", 32'(state), 32'(m_st));
    chk("ack count", ack_seen, exp_acks);
  endtask

  initial begin
    m_st = PMC_FULL_ACQ;
    repeat (4) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    @(posedge ref_clk_i);
    #1;
    chk("state", 32'(state), 32'(PMC_FULL_ACQ));
    chk("aug aic gnd", {aug, interference_canceller, gnd}, 3'b110);
    apb(1'b0, `PMC_ADDR_CTRL, 32'h0);
    chk("ctrl", rq, `PMC_CTRL_RST);
    apb(1'b0, `PMC_ADDR_STATUS, 32'h0);
    chk("tones", rq[11:8], `PMC_AIC_MAX_TONES);
    apb(1'b0, 12'h0fc, 32'h0);
    chk("unmapped", re, 1'b1);
    $display("test reset done");
    // ground corrections chosen, augmentation and canceller switched off
    apb(1'b1, `PMC_ADDR_CTRL, 32'h4);
    rtcm <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    #1;
    chk("aug aic gnd", {aug, interference_canceller, gnd}, 3'b001);
    rtcm <= 1'b0;
    $display("test corrections done");
    posv <= 1'b1;
    ephv <= 1'b1;
    wait_st(PMC_FULL_TRACK, 20);
    chk("track", pwr.track_en, 1'b1);
    posv <= 1'b0;
    ephv <= 1'b0;
    wait_st(PMC_FULL_ACQ, 20);
    $display("test tracking done");
    // random periods, read back, then periodic standby with one retry pair
    for (int i = 0; i < 4; i++) begin
      per[i] = 5 + int'(lfsr() % 6);
      apb(1'b1, 12'(`PMC_ADDR_RUN + 4 * i), 32'(per[i]));
      apb(1'b0, 12'(`PMC_ADDR_RUN + 4 * i), 32'h0);
      chk("period reg", rq, 32'(per[i]));
    end
    cmd(`PMC_OP_POWER, `PMC_ARG_PER_STANDBY, 1'b0);
    wait_st(PMC_PER_OFF, 200);
    wait_st(PMC_PER_ON, 200);
    rng("off time", per[1]);
    acqf <= 1'b1;
    @(posedge ref_clk_i);
    acqf <= 1'b0;
    wait_st(PMC_PER_OFF, 200);
    rng("retry on", per[2]);
    wait_st(PMC_PER_ON, 200);
    rng("retry off", per[3]);
    m_st = PMC_PER_ON;
    cmd(`PMC_OP_POWER, `PMC_ARG_FULL, 1'b0);
    cmd(`PMC_OP_POWER, `PMC_ARG_PER_BACKUP, 1'b0);
    wait_st(PMC_PER_OFF, 200);
    @(posedge ref_clk_i);
    #1;
    chk("osc off", pwr.osc_en, 1'b0);
    wait_st(PMC_PER_ON, 200);
    m_st = PMC_PER_ON;
    cmd(`PMC_OP_POWER, `PMC_ARG_FULL, 1'b0);
    $display("test periodic done");
    cmd(`PMC_OP_POWER, `PMC_ARG_ADAPTIVE, 1'b0);
    wait_st(PMC_ADAPT_OFF, 13000);
    wait_st(PMC_ADAPT_ON, 13000);
    rng("adaptive off", `PMC_ADAPT_OFF_MOVE_MS);
    moving <= 1'b0;
    wait_st(PMC_ADAPT_OFF, 13000);
    wait_st(PMC_ADAPT_ON, 26000);
    rng("adaptive still", `PMC_ADAPT_OFF_STILL_MS);
    m_st = PMC_ADAPT_ON;
    cmd(`PMC_OP_POWER, `PMC_ARG_FULL, 1'b0);
    $display("test adaptive done");
    for (int a = 0; a < 2; a++) begin
      cmd(`PMC_OP_STANDBY, 8'(a), 1'b0);
      chk("osc rf bb", {pwr.osc_en, pwr.rf_en, pwr.bb_en}, (a == 1) ? 3'b100 : 3'b000);
      wake <= 1'b1;
      @(posedge ref_clk_i);
      wake <= 1'b0;
      wait_st(PMC_FULL_ACQ, 20);
      m_st = PMC_FULL_ACQ;
    end
    $display("test standby done");
    cmd(`PMC_OP_POWER, `PMC_ARG_PER_STANDBY, 1'b1);
    $display("test checksum done");
    cmd(`PMC_OP_POWER, `PMC_ARG_BACKUP, 1'b0);
    cmd(`PMC_OP_POWER, `PMC_ARG_FULL, 1'b0);
    hold_low <= 1'b1;
    cmd(`PMC_OP_POWER, `PMC_ARG_BACKUP, 1'b0);
    cmd(`PMC_OP_POWER, `PMC_ARG_FULL, 1'b0);
    // a short high blip on the pin is not an exit
    hold_low <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    hold_low <= 1'b1;
    repeat (20) @(posedge ref_clk_i);
    #1;
    chk("state", 32'(state), 32'(PMC_BACKUP));
    chk("io off", pwr.io_en, 1'b0);
    exit_p <= 1'b1;
    @(posedge ref_clk_i);
    exit_p <= 1'b0;
    wait_st(PMC_FULL_ACQ, 40);
    chk("hot start", hot, 1'b1);
    hold_low <= 1'b0;
    $display("test backup done");
    // supply loss, return, then the pin falls to end backup
    supply <= 1'b0;
    wait_st(PMC_BACKUP, 10);
    supply <= 1'b1;
    repeat (8) @(posedge ref_clk_i);
    #1;
    chk("state", 32'(state), 32'(PMC_BACKUP));
    hold_low <= 1'b1;
    wait_st(PMC_FULL_ACQ, 20);
    chk("hot start", hot, 1'b1);
    apb(1'b0, `PMC_ADDR_CTRL, 32'h0);
    chk("ctrl", rq, `PMC_CTRL_RST);
    $display("test supply done");
    end_sim();
  end
endmodule
